//--- logic/isp_pkg.sv
// Constants for the interrupt source priority logic: flag slots, source
// numbers, vector layout and reset values.
// Assumes a single system clock domain shared with the CPU core.
package isp_pkg;

  // Flag slots held by the block, one sticky bit each
  localparam int FL_EXT     = 0;
  localparam int FL_PLL     = 1;
  localparam int FL_T1C0    = 2;
  localparam int FL_T1C1    = 3;
  localparam int FL_T1OV    = 4;
  localparam int FL_T2C0    = 5;
  localparam int FL_T2C1    = 6;
  localparam int FL_T2OV    = 7;
  localparam int FL_SPRX    = 8;
  localparam int FL_SPOV    = 9;
  localparam int FL_SPMF    = 10;
  localparam int FL_SPTX    = 11;
  localparam int FL_AOR     = 12;
  localparam int FL_ANF     = 13;
  localparam int FL_AFE     = 14;
  localparam int FL_APE     = 15;
  localparam int FL_ARX     = 16;
  localparam int FL_AIDL    = 17;
  localparam int FL_ATX     = 18;
  localparam int FL_ATC     = 19;
  localparam int FL_KEY     = 20;
  localparam int FL_CONV    = 21;
  localparam int FL_TB      = 22;
  localparam int NUM_FLAGS  = 23;

  // Source numbers, 0 ranks highest
  localparam int SRC_TRAP   = 0;
  localparam int SRC_EXT    = 1;
  localparam int SRC_PLL    = 2;
  localparam int SRC_T1C0   = 3;
  localparam int SRC_T1C1   = 4;
  localparam int SRC_T1OV   = 5;
  localparam int SRC_T2C0   = 6;
  localparam int SRC_T2C1   = 7;
  localparam int SRC_T2OV   = 8;
  localparam int SRC_SPRX   = 9;
  localparam int SRC_SPTX   = 10;
  localparam int SRC_AERR   = 11;
  localparam int SRC_ARX    = 12;
  localparam int SRC_ATX    = 13;
  localparam int SRC_KEY    = 14;
  localparam int SRC_CONV   = 15;
  localparam int SRC_TB     = 16;
  localparam int NUM_SRC    = 17;
  localparam int SRC_W      = 5;

  // Vector table: source 0 at the top, each lower rank two bytes below
  localparam logic [15:0] VEC_BASE = 16'hFFFC;
  localparam logic [15:0] VEC_STEP = 16'h0002;
  localparam logic [15:0] PC_ADJ   = 16'h0001;

  // Reset values and default widths
  localparam logic        FLAG_RST  = 1'h0;
  localparam logic [2:0]  SYNC_RST  = 3'h7;
  localparam int          TMR_W_DEF = 16;

endpackage : isp_pkg

//--- logic/isp_flag.sv
// One sticky interrupt flag with its enable gate.
// Assumes set and clear pulses come from logic on mclk.
`timescale 1ns/1ps
`default_nettype none
module isp_flag (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic sys_rst,
  // Event, clear and gate
  input  wire logic setEv,
  input  wire logic clrEv,
  input  wire logic irqEn,
  // Flag and request
  output var  logic flag_r,
  output      logic req
);
  import isp_pkg::*;

  // Set dominates a simultaneous clear so no event is lost
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      flag_r <= FLAG_RST;
    end else if (setEv) begin
      flag_r <= 1'b1;
    end else if (clrEv) begin
      flag_r <= 1'b0;
    end
  end

  // Enable passes the flag on as a request
  assign req = flag_r & irqEn;

  AST_SET_WINS: assert property (@(posedge mclk) disable iff (sys_rst)
    setEv |=> flag_r) else $error("flag lost an event");

endmodule // isp_flag
`default_nettype wire

//--- logic/isp_source_priority.sv
// Interrupt source aggregation and fixed-priority selection.
// Assumes peripherals and CPU run on mclk; pins are asynchronous.
// Overview of operation
// - CPU global mask blocks every request except the software trap.
// - Simultaneous requests are ranked by source number, zero highest.
// - The software trap raises an interrupt no mask can suppress.
// - Trap stacks PC unchanged; hardware interrupts stack PC minus one.
// - A break point hit forces the CPU to execute the software trap.
// - Low level on the external request pin latches a request.
// - Any PLL lock change sets the PLL flag; its enable gates it.
// - Timer one wraps from modulo to zero: set wrap flag, enable gates.
// - Timer channel capture or compare sets channel flag, gated by enable.
// - Timer two wrap sets its own wrap flag, gated by its enable.
// - Timer two channel flags request only with their channel enable.
// - Serial receive transfer sets receive-full flag; receive enable gates.
// - Serial transmit transfer sets transmit-empty flag; transmit enable gates.
// - Slave select rising mid-transfer in slave mode sets select fault.
// - Slave select low in master mode sets select fault; error enable gates.
// - New byte before previous was read sets serial overflow flag.
// - Four async error flags, each enabled, merge into source 11.
// - Async receive-full and idle flags merge into source 12.
// - Async transmit-empty and done flags merge into source 13.
// - Keypad flag requests source 14 unless its mask bit is set.
// - Conversion done flag with its enable requests source 15.
// - Timebase rollover flag with its enable requests source 16.
// - Each status bit reads one the cycle after its source request is present.
`timescale 1ns/1ps
`default_nettype none
module isp_source_priority #(
  parameter int TMR_W = isp_pkg::TMR_W_DEF
) (
  // Clock and reset
  input  wire logic                          mclk,
  input  wire logic                          sys_rst,
  // Asynchronous pins
  input  wire logic                          extReqPinN,
  input  wire logic                          pllLock,
  input  wire logic                          selectPinN,
  // CPU side
  input  wire logic                          cpuIMask,
  input  wire logic                          cpuRecog,
  input  wire logic                          softwareTrapExec,
  input  wire logic [15:0]                   cpuPc,
  input  wire logic                          breakHit,
  // Timers
  input  wire logic                          tmr1Tick,
  input  wire logic [TMR_W-1:0]              tmr1Count,
  input  wire logic [TMR_W-1:0]              tmr1Mod,
  input  wire logic                          tmr1Ch0Ev,
  input  wire logic                          tmr1Ch1Ev,
  input  wire logic                          tmr2Tick,
  input  wire logic [TMR_W-1:0]              tmr2Count,
  input  wire logic [TMR_W-1:0]              tmr2Mod,
  input  wire logic                          tmr2Ch0Ev,
  input  wire logic                          tmr2Ch1Ev,
  // Synchronous serial
  input  wire logic                          spiRxXfer,
  input  wire logic                          spiTxXfer,
  input  wire logic                          spiMaster,
  input  wire logic                          spiBusy,
  input  wire logic                          selectFaultDetectEn,
  // Asynchronous serial events
  input  wire logic                          asyncOverrunEv,
  input  wire logic                          asyncNoiseEv,
  input  wire logic                          asyncFramingEv,
  input  wire logic                          asyncParityEv,
  input  wire logic                          asyncRxFullEv,
  input  wire logic                          asyncIdleEv,
  input  wire logic                          asyncTxEmptyEv,
  input  wire logic                          asyncTxDoneEv,
  // Other sources
  input  wire logic                          keypadEv,
  input  wire logic                          conversionDoneEv,
  input  wire logic                          timebaseRolloverEv,
  // Enables and masks
  input  wire logic                          externalRequestMask,
  input  wire logic                          pllLockChangeIrqEn,
  input  wire logic                          tmr1WrapIrqEn,
  input  wire logic                          tmr1Ch0IrqEn,
  input  wire logic                          tmr1Ch1IrqEn,
  input  wire logic                          tmr2WrapIrqEn,
  input  wire logic                          tmr2Ch0IrqEn,
  input  wire logic                          tmr2Ch1IrqEn,
  input  wire logic                          syncSerialRxIrqEn,
  input  wire logic                          syncSerialTxIrqEn,
  input  wire logic                          syncSerialErrorIrqEn,
  input  wire logic                          asyncOverrunIrqEn,
  input  wire logic                          asyncNoiseIrqEn,
  input  wire logic                          asyncFramingIrqEn,
  input  wire logic                          asyncParityIrqEn,
  input  wire logic                          asyncRxIrqEn,
  input  wire logic                          asyncIdleIrqEn,
  input  wire logic                          asyncTxIrqEn,
  input  wire logic                          asyncTxDoneIrqEn,
  input  wire logic                          keypadRequestMask,
  input  wire logic                          conversionIrqEn,
  input  wire logic                          timebaseIrqEn,
  // Software clears, one pulse bit per flag slot
  input  wire logic [isp_pkg::NUM_FLAGS-1:0] flagClr,
  // Flag and status read-back
  output      logic [isp_pkg::NUM_FLAGS-1:0] flagState,
  output var  logic [isp_pkg::NUM_SRC-1:1]   reqStatus_r,
  // Answer to the CPU
  output var  logic                          irqPending_r,
  output var  logic                          irqTake_r,
  output var  logic [isp_pkg::SRC_W-1:0]     irqSrc_r,
  output var  logic [15:0]                   irqVec_r,
  output var  logic [15:0]                   stackedPc_r,
  output var  logic                          forceTrap_r
);
  import isp_pkg::*;
  if (TMR_W < 2 || TMR_W > 32) begin : gChk
    $error("TMR_W must lie between 2 and 32");
  end
  logic [2:0]           syncA_r;
  logic [2:0]           syncB_r;
  logic                 lockPrev_r;
  logic [2:0]           lockPrimed_r;
  logic                 selPrev_r;
  logic                 trapPend_r;
  logic [NUM_FLAGS-1:0] setEv;
  logic [NUM_FLAGS-1:0] enVec;
  logic [NUM_FLAGS-1:0] flagReq;
  logic [NUM_SRC-1:0]   srcReq;
  logic [NUM_SRC-1:0]   activeReq;
  logic [SRC_W-1:0]     bestSrc;
  logic                 anyActive;
  logic                 extLow;
  logic                 lockSync;
  logic                 selHigh;
  logic                 lockChange;
  logic                 selRise;
  // Two-flop synchronisers for the pins: ext, lock, select
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      syncA_r <= SYNC_RST;
      syncB_r <= SYNC_RST;
    end else begin
      syncA_r <= {selectPinN, pllLock, extReqPinN};
      syncB_r <= syncA_r;
    end
  end
  assign extLow   = ~syncB_r[0];
  assign lockSync = syncB_r[1];
  assign selHigh  = syncB_r[2];
  // Edge history for lock and select; lock edges count only once the
  // synchroniser and the history hold real pin samples, so the preset
  // synchroniser value after reset raises no false lock change
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      lockPrev_r   <= 1'b0;
      lockPrimed_r <= 3'h0;
      selPrev_r    <= 1'b1;
    end else begin
      lockPrev_r   <= lockSync;
      lockPrimed_r <= {lockPrimed_r[1:0], 1'b1};
      selPrev_r    <= selHigh;
    end
  end
  assign lockChange = lockPrimed_r[2] & (lockSync ^ lockPrev_r);
  assign selRise    = selHigh & ~selPrev_r;
  // Events that set each flag slot
  always_comb begin
    setEv           = '0;
    setEv[FL_EXT]   = extLow;
    setEv[FL_PLL]   = lockChange;
    setEv[FL_T1OV]  = tmr1Tick && (tmr1Count == tmr1Mod);
    setEv[FL_T1C0]  = tmr1Ch0Ev;
    setEv[FL_T1C1]  = tmr1Ch1Ev;
    setEv[FL_T2OV]  = tmr2Tick && (tmr2Count == tmr2Mod);
    setEv[FL_T2C0]  = tmr2Ch0Ev;
    setEv[FL_T2C1]  = tmr2Ch1Ev;
    setEv[FL_SPRX]  = spiRxXfer;
    setEv[FL_SPTX]  = spiTxXfer;
    setEv[FL_SPMF]  = selectFaultDetectEn &&
                      ((!spiMaster && spiBusy && selRise) ||
                       (spiMaster && !selHigh));
    setEv[FL_SPOV]  = spiRxXfer && flagState[FL_SPRX];
    setEv[FL_AOR]   = asyncOverrunEv;
    setEv[FL_ANF]   = asyncNoiseEv;
    setEv[FL_AFE]   = asyncFramingEv;
    setEv[FL_APE]   = asyncParityEv;
    setEv[FL_ARX]   = asyncRxFullEv;
    setEv[FL_AIDL]  = asyncIdleEv;
    setEv[FL_ATX]   = asyncTxEmptyEv;
    setEv[FL_ATC]   = asyncTxDoneEv;
    setEv[FL_KEY]   = keypadEv;
    setEv[FL_CONV]  = conversionDoneEv;
    setEv[FL_TB]    = timebaseRolloverEv;
  end
  // Per-slot gates; the external request and keypad sources are masked rather than enabled
  always_comb begin
    enVec           = '0;
    enVec[FL_EXT]   = ~externalRequestMask;
    enVec[FL_PLL]   = pllLockChangeIrqEn;
    enVec[FL_T1OV]  = tmr1WrapIrqEn;
    enVec[FL_T1C0]  = tmr1Ch0IrqEn;
    enVec[FL_T1C1]  = tmr1Ch1IrqEn;
    enVec[FL_T2OV]  = tmr2WrapIrqEn;
    enVec[FL_T2C0]  = tmr2Ch0IrqEn;
    enVec[FL_T2C1]  = tmr2Ch1IrqEn;
    enVec[FL_SPRX]  = syncSerialRxIrqEn;
    enVec[FL_SPTX]  = syncSerialTxIrqEn;
    enVec[FL_SPMF]  = syncSerialErrorIrqEn;
    enVec[FL_SPOV]  = syncSerialErrorIrqEn;
    enVec[FL_AOR]   = asyncOverrunIrqEn;
    enVec[FL_ANF]   = asyncNoiseIrqEn;
    enVec[FL_AFE]   = asyncFramingIrqEn;
    enVec[FL_APE]   = asyncParityIrqEn;
    enVec[FL_ARX]   = asyncRxIrqEn;
    enVec[FL_AIDL]  = asyncIdleIrqEn;
    enVec[FL_ATX]   = asyncTxIrqEn;
    enVec[FL_ATC]   = asyncTxDoneIrqEn;
    enVec[FL_KEY]   = ~keypadRequestMask;
    enVec[FL_CONV]  = conversionIrqEn;
    enVec[FL_TB]    = timebaseIrqEn;
  end
  // One sticky flag per slot
  for (genvar g = 0; g < NUM_FLAGS; g++) begin : gFlag
    isp_flag uFlag (
      .mclk    (mclk),
      .sys_rst (sys_rst),
      .setEv   (setEv[g]),
      .clrEv   (flagClr[g]),
      .irqEn   (enVec[g]),
      .flag_r  (flagState[g]),
      .req     (flagReq[g])
    );
  end
  // Merge slot requests into numbered source lines
  always_comb begin
    srcReq           = '0;
    srcReq[SRC_TRAP] = trapPend_r;
    srcReq[SRC_EXT]  = flagReq[FL_EXT];
    srcReq[SRC_PLL]  = flagReq[FL_PLL];
    srcReq[SRC_T1C0] = flagReq[FL_T1C0];
    srcReq[SRC_T1C1] = flagReq[FL_T1C1];
    srcReq[SRC_T1OV] = flagReq[FL_T1OV];
    srcReq[SRC_T2C0] = flagReq[FL_T2C0];
    srcReq[SRC_T2C1] = flagReq[FL_T2C1];
    srcReq[SRC_T2OV] = flagReq[FL_T2OV];
    srcReq[SRC_SPRX] = flagReq[FL_SPRX] | flagReq[FL_SPOV] | flagReq[FL_SPMF];
    srcReq[SRC_SPTX] = flagReq[FL_SPTX];
    srcReq[SRC_AERR] = |flagReq[FL_APE:FL_AOR];
    srcReq[SRC_ARX]  = flagReq[FL_ARX] | flagReq[FL_AIDL];
    srcReq[SRC_ATX]  = flagReq[FL_ATX] | flagReq[FL_ATC];
    srcReq[SRC_KEY]  = flagReq[FL_KEY];
    srcReq[SRC_CONV] = flagReq[FL_CONV];
    srcReq[SRC_TB]   = flagReq[FL_TB];
  end
  // Global mask stops all hardware lines; the trap line bypasses it
  assign activeReq = {srcReq[NUM_SRC-1:1] & {(NUM_SRC-1){~cpuIMask}}, srcReq[0]};
  assign anyActive = |activeReq;
  // Lowest-numbered active line wins
  always_comb begin
    bestSrc = '0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (activeReq[i]) begin
        bestSrc = SRC_W'(i);
      end
    end
  end
  // Trap pending from execution until taken; a new trap wins over the take
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      trapPend_r <= 1'b0;
    end else if (softwareTrapExec) begin
      trapPend_r <= 1'b1;
    end else if (cpuRecog) begin
      trapPend_r <= 1'b0;
    end
  end
  // Break point hit makes the CPU run the trap instruction
  always_ff @(posedge mclk) begin
    forceTrap_r <= !sys_rst && breakHit;
  end
  // Status read-back of numbered requests 1 to 16; the trap line has no status bit
  always_ff @(posedge mclk) begin
    reqStatus_r <= sys_rst ? '0 : srcReq[NUM_SRC-1:1];
  end
  // Answer to the CPU at the recognition point
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      irqPending_r <= 1'b0;
      irqTake_r    <= 1'b0;
      irqSrc_r     <= '0;
      irqVec_r     <= VEC_BASE;
      stackedPc_r  <= '0;
    end else begin
      irqPending_r <= anyActive;
      irqTake_r    <= cpuRecog && anyActive;
      if (cpuRecog && anyActive) begin
        irqSrc_r    <= bestSrc;
        irqVec_r    <= VEC_BASE - 16'(bestSrc) * VEC_STEP;
        stackedPc_r <= (bestSrc == SRC_W'(SRC_TRAP)) ? cpuPc : cpuPc - PC_ADJ;
      end
    end
  end
  // Helper: lines ranked above the selected source
  logic [NUM_SRC-1:0] aboveSel;
  assign aboveSel = NUM_SRC'((17'h00001 << irqSrc_r) - 17'h00001);
  AST_MASK_BLOCKS: assert property (@(posedge mclk) disable iff (sys_rst)
    cpuIMask && !trapPend_r |=> !irqTake_r) else $error("masked take");
  AST_PRIORITY: assert property (@(posedge mclk) disable iff (sys_rst)
    irqTake_r |-> (($past(activeReq) & aboveSel) == '0)) else $error("priority broken");
  AST_TRAP_UNMASKED: assert property (@(posedge mclk) disable iff (sys_rst)
    cpuRecog && trapPend_r |=> irqTake_r && irqSrc_r == '0) else $error("trap not taken");
  AST_STACK_PC: assert property (@(posedge mclk) disable iff (sys_rst)
    irqTake_r |-> stackedPc_r == ((irqSrc_r == '0) ? $past(cpuPc) : $past(cpuPc) - PC_ADJ))
    else $error("stacked PC wrong");
  AST_BREAK_TRAP: assert property (@(posedge mclk) disable iff (sys_rst)
    breakHit |=> forceTrap_r) else $error("break did not force trap");
  AST_EXT_LATCH: assert property (@(posedge mclk) disable iff (sys_rst)
    !extReqPinN [*3] |=> flagState[FL_EXT]) else $error("pin low not latched");
  AST_PLL_CHANGE: assert property (@(posedge mclk) disable iff (sys_rst)
    lockChange |=> flagState[FL_PLL]) else $error("lock change missed");
  AST_T1_WRAP: assert property (@(posedge mclk) disable iff (sys_rst)
    tmr1Tick && tmr1Count == tmr1Mod |=> flagState[FL_T1OV]) else $error("wrap missed");
  AST_SPI_OVERFLOW: assert property (@(posedge mclk) disable iff (sys_rst)
    spiRxXfer && flagState[FL_SPRX] |=> flagState[FL_SPOV]) else $error("overflow missed");
  AST_MASTER_FAULT: assert property (@(posedge mclk) disable iff (sys_rst)
    spiMaster && selectFaultDetectEn && !selHigh |=> flagState[FL_SPMF])
    else $error("master fault missed");
  AST_STATUS: assert property (@(posedge mclk) disable iff (sys_rst)
    ##1 reqStatus_r == $past(srcReq[NUM_SRC-1:1])) else $error("status mismatch");
  AST_VECTOR: assert property (@(posedge mclk) disable iff (sys_rst)
    irqTake_r |-> irqVec_r == VEC_BASE - 16'(irqSrc_r) * VEC_STEP) else $error("bad vector");
  COV_TRAP: cover property (@(posedge mclk) disable iff (sys_rst) irqTake_r && irqSrc_r == '0);
  COV_TIMEBASE: cover property (@(posedge mclk) disable iff (sys_rst)
    irqTake_r && irqSrc_r == SRC_W'(SRC_TB));
  COV_CONTEND: cover property (@(posedge mclk) disable iff (sys_rst)
    cpuRecog && activeReq[SRC_EXT] && activeReq[SRC_TB]);
  COV_MASKED: cover property (@(posedge mclk) disable iff (sys_rst) cpuIMask && |srcReq[NUM_SRC-1:1]);
endmodule // isp_source_priority
`default_nettype wire

//--- testbench/isp_cpu_model.sv
// CPU core model facing the interrupt source priority logic.
// Assumes the block's mclk domain and its synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module isp_cpu_model (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  // Bench control
  input  wire logic        recogEn,
  input  wire logic [3:0]  lag,
  input  wire logic        trapCmd,
  // Answer from the block
  input  wire logic        irqPending_r,
  input  wire logic        forceTrap_r,
  // CPU outputs
  output var  logic        cpuRecog,
  output var  logic        softwareTrapExec,
  output var  logic [15:0] cpuPc,
  output var  logic [15:0] recogPc
);
  logic [3:0] waitCnt;
  logic       done;
  // Program counter moves every cycle, so a stale sample shows up
  always_ff @(posedge mclk) cpuPc <= sys_rst ? 16'h8000 : cpuPc + 16'h0001;
  // Trap runs on bench command or when the break logic forces it
  always_ff @(posedge mclk) softwareTrapExec <= !sys_rst && (trapCmd || forceTrap_r);
  // PC seen by the block at the recognition edge
  always_ff @(posedge mclk) if (cpuRecog) recogPc <= cpuPc;
  // One recognition per bench request, after lag cycles of pending
  always_ff @(posedge mclk) begin
    cpuRecog <= 1'b0;
    if (sys_rst || !recogEn) begin
      waitCnt <= 4'h0;
      done    <= 1'b0;
    end else if (!done && irqPending_r) begin
      if (waitCnt == lag) begin
        cpuRecog <= 1'b1;
        done     <= 1'b1;
      end else begin
        waitCnt <= waitCnt + 4'h1;
      end
    end
  end
endmodule // isp_cpu_model
`default_nettype wire

//--- testbench/tb.sv
// Self-checking bench for the interrupt source priority logic.
// Assumes isp_pkg and the CPU model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import isp_pkg::*;
  logic mclk, sys_rst, extN, pllLock, selN, cpuIMask, breakHit, recogEn, trapCmd;
  logic spiMaster, spiBusy, sfdEn, cpuRecog, softwareTrapExec, irqPending_r, irqTake_r;
  logic forceTrap_r;
  logic [3:0]           lag;
  logic [15:0]          cnt1, mod1, cpuPc, recogPc, irqVec_r, stackedPc_r;
  logic [NUM_FLAGS-1:0] ev, en, clr, flagState;
  logic [NUM_SRC-1:1]   reqStatus_r;
  logic [SRC_W-1:0]     irqSrc_r;
  int err_count, cmp_count;
  int tbl [NUM_FLAGS] = '{1,2,3,4,5,6,7,8,9,9,9,10,11,11,11,11,12,12,13,13,14,15,16};
  localparam logic [NUM_FLAGS-1:0] ONE = 23'h000001;

  isp_source_priority i_isp_source_priority (
    .mclk(mclk), .sys_rst(sys_rst), .extReqPinN(extN), .pllLock(pllLock), .selectPinN(selN),
    .cpuIMask(cpuIMask), .cpuRecog(cpuRecog), .softwareTrapExec(softwareTrapExec),
    .cpuPc(cpuPc), .breakHit(breakHit), .tmr1Tick(ev[FL_T1OV]), .tmr1Count(cnt1),
    .tmr1Mod(mod1), .tmr1Ch0Ev(ev[FL_T1C0]), .tmr1Ch1Ev(ev[FL_T1C1]),
    .tmr2Tick(ev[FL_T2OV]), .tmr2Count(cnt1), .tmr2Mod(mod1), .tmr2Ch0Ev(ev[FL_T2C0]),
    .tmr2Ch1Ev(ev[FL_T2C1]), .spiRxXfer(ev[FL_SPRX]), .spiTxXfer(ev[FL_SPTX]),
    .spiMaster(spiMaster), .spiBusy(spiBusy), .selectFaultDetectEn(sfdEn),
    .asyncOverrunEv(ev[FL_AOR]), .asyncNoiseEv(ev[FL_ANF]), .asyncFramingEv(ev[FL_AFE]),
    .asyncParityEv(ev[FL_APE]), .asyncRxFullEv(ev[FL_ARX]), .asyncIdleEv(ev[FL_AIDL]),
    .asyncTxEmptyEv(ev[FL_ATX]), .asyncTxDoneEv(ev[FL_ATC]), .keypadEv(ev[FL_KEY]),
    .conversionDoneEv(ev[FL_CONV]), .timebaseRolloverEv(ev[FL_TB]),
    .externalRequestMask(!en[FL_EXT]), .pllLockChangeIrqEn(en[FL_PLL]),
    .tmr1WrapIrqEn(en[FL_T1OV]), .tmr1Ch0IrqEn(en[FL_T1C0]), .tmr1Ch1IrqEn(en[FL_T1C1]),
    .tmr2WrapIrqEn(en[FL_T2OV]), .tmr2Ch0IrqEn(en[FL_T2C0]), .tmr2Ch1IrqEn(en[FL_T2C1]),
    .syncSerialRxIrqEn(en[FL_SPRX]), .syncSerialTxIrqEn(en[FL_SPTX]),
    .syncSerialErrorIrqEn(en[FL_SPOV]), .asyncOverrunIrqEn(en[FL_AOR]),
    .asyncNoiseIrqEn(en[FL_ANF]), .asyncFramingIrqEn(en[FL_AFE]),
    .asyncParityIrqEn(en[FL_APE]), .asyncRxIrqEn(en[FL_ARX]), .asyncIdleIrqEn(en[FL_AIDL]),
    .asyncTxIrqEn(en[FL_ATX]), .asyncTxDoneIrqEn(en[FL_ATC]),
    .keypadRequestMask(!en[FL_KEY]), .conversionIrqEn(en[FL_CONV]),
    .timebaseIrqEn(en[FL_TB]), .flagClr(clr), .flagState(flagState),
    .reqStatus_r(reqStatus_r), .irqPending_r(irqPending_r), .irqTake_r(irqTake_r),
    .irqSrc_r(irqSrc_r), .irqVec_r(irqVec_r), .stackedPc_r(stackedPc_r),
    .forceTrap_r(forceTrap_r));

  isp_cpu_model i_isp_cpu_model (
    .mclk(mclk), .sys_rst(sys_rst), .recogEn(recogEn), .lag(lag), .trapCmd(trapCmd),
    .irqPending_r(irqPending_r), .forceTrap_r(forceTrap_r), .cpuRecog(cpuRecog),
    .softwareTrapExec(softwareTrapExec), .cpuPc(cpuPc), .recogPc(recogPc));

  // Free-running 50 ns clock
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  task automatic step;
    @(posedge mclk);
    #1;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic stop_test;
    if (err_count == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic fire(input logic [NUM_FLAGS-1:0] m);
    ev = m;
    step;
    ev = '0;
  endtask
  // Ask the CPU model for one recognition and wait for the take pulse
  task automatic take(input logic expTake);
    int n;
    n = 0;
    recogEn = 1'b1;
    while (irqTake_r !== 1'b1 && n < 30) begin
      step;
      n++;
    end
    recogEn = 1'b0;
    chk("take", irqTake_r, expTake);
    step;
  endtask
  task automatic checkTake(input int s);
    take(1'b1);
    chk("src", irqSrc_r, s);
    chk("vec", irqVec_r, 16'hFFFC - 16'h0002 * s);
    chk("pc", stackedPc_r, (s == 0) ? recogPc : recogPc - 16'h0001);
  endtask
  task automatic clrSrc(input int s);
    for (int j = 0; j < NUM_FLAGS; j++) clr[j] = (tbl[j] == s);
    step;
    clr = '0;
    step;
  endtask
  function automatic bit isEv(input int i);
    return !(i inside {FL_EXT, FL_PLL, FL_SPOV, FL_SPMF});
  endfunction

  // Watchdog against a hang
  initial begin
    repeat (10000) @(posedge mclk);
    err_count++;
    stop_test;
  end

  // Test sequence
  initial begin
    logic [NUM_FLAGS-1:0] m;
    err_count = 0; cmp_count = 0; sys_rst = 1'b1; extN = 1'b1; pllLock = 1'b0;
    selN = 1'b1; cpuIMask = 1'b0; breakHit = 1'b0; recogEn = 1'b0; trapCmd = 1'b0;
    spiMaster = 1'b0; spiBusy = 1'b0; sfdEn = 1'b0; lag = 4'h2;
    cnt1 = 16'h0005; mod1 = 16'h0005; ev = '0; en = '1; clr = '0;
    repeat (3) step;
    sys_rst = 1'b0;
    step;
    chk("rstFlags", flagState, 0);
    chk("rstVec", irqVec_r, 16'hFFFC);
    chk("rstPend", irqPending_r, 0);
    // Each event source with its enable set, then cleared
    for (int i = 0; i < NUM_FLAGS; i++) if (isEv(i)) for (int k = 1; k >= 0; k--) begin
      en[i] = k[0];
      fire(ONE << i);
      chk("flag", flagState[i], 1);
      step;
      chk("status", reqStatus_r[tbl[i]], k);
      if (k == 1) checkTake(tbl[i]);
      clrSrc(tbl[i]);
      en[i] = 1'b1;
    end
    // Tick without a modulo match does not wrap
    mod1 = 16'h0006;
    fire(ONE << FL_T1OV);
    chk("noWrap", flagState[FL_T1OV], 0);
    mod1 = 16'h0005;
    // All event sources at once come out in rank order
    m = '0;
    for (int i = 0; i < NUM_FLAGS; i++) m[i] = isEv(i);
    fire(m);
    for (int s = 3; s <= 16; s++) begin
      checkTake(s);
      clrSrc(s);
    end
    // Global mask blocks hardware sources, not the trap
    cpuIMask = 1'b1;
    lag = 4'h0;
    fire(ONE << FL_CONV);
    step;
    chk("maskPend", irqPending_r, 0);
    take(1'b0);
    trapCmd = 1'b1;
    step;
    trapCmd = 1'b0;
    checkTake(0);
    cpuIMask = 1'b0;
    checkTake(15);
    clrSrc(15);
    // Clear and event in one cycle: the event wins
    clr[FL_CONV] = 1'b1;
    fire(ONE << FL_CONV);
    clr = '0;
    chk("setWins", flagState[FL_CONV], 1);
    clrSrc(15);
    // Break point forces a trap
    breakHit = 1'b1;
    step;
    breakHit = 1'b0;
    chk("force", forceTrap_r, 1);
    checkTake(0);
    // External pin held low
    extN = 1'b0;
    repeat (4) step;
    chk("ext", flagState[FL_EXT], 1);
    checkTake(1);
    extN = 1'b1;
    repeat (3) step;
    clrSrc(1);
    // Lock gained, then lost
    for (int k = 0; k < 2; k++) begin
      pllLock = !pllLock;
      repeat (4) step;
      chk("pll", flagState[FL_PLL], 1);
      if (k == 0) checkTake(2);
      clrSrc(2);
    end
    // Master sees select low
    spiMaster = 1'b1;
    sfdEn = 1'b1;
    selN = 1'b0;
    repeat (4) step;
    chk("mfault", flagState[FL_SPMF], 1);
    checkTake(9);
    selN = 1'b1;
    repeat (3) step;
    clrSrc(9);
    // Slave: select low is legal, a rise mid-transfer is a fault
    spiMaster = 1'b0;
    spiBusy = 1'b1;
    selN = 1'b0;
    repeat (4) step;
    chk("sNoFault", flagState[FL_SPMF], 0);
    selN = 1'b1;
    repeat (4) step;
    chk("sFault", flagState[FL_SPMF], 1);
    spiBusy = 1'b0;
    clrSrc(9);
    // Second byte before the first is read
    fire(ONE << FL_SPRX);
    fire(ONE << FL_SPRX);
    chk("ovf", flagState[FL_SPOV], 1);
    checkTake(9);
    clrSrc(9);
    stop_test;
  end
endmodule // tb
`default_nettype wire
